// ---- hw/timer8_wave_ctrl.sv ----
// 8-bit timer with waveform generation, AHB-Lite registers and interrupt.
// Assumes one synchronous clock, a single AHB-Lite master and pins
// resolved outside from the output and output-enable signals.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"

module timer8_wave_ctrl (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Port logic that owns the pins when the timer does not
    input wire logic port_out_a,
    input wire logic port_dir_a,
    input wire logic port_out_b,
    input wire logic port_dir_b,
    // Waveform pins
    output logic pin_a_o,
    output logic pin_a_oe,
    output logic pin_b_o,
    output logic pin_b_oe,
    // Interrupt
    output logic irq
);
    import timer8_pkg::*;

    bus_state_type bus_r;
    logic [31:0] addr_r;
    logic [31:0] hrdata_r;
    logic [7:0] ctl_a_r;
    logic [7:0] ctl_b_r;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic dir_up_r;
    logic dir_up_nxt;
    logic block_r;
    logic [7:0] cmp_a_wr_r;
    logic [7:0] cmp_b_wr_r;
    logic [7:0] cmp_a_act_r;
    logic [7:0] cmp_b_act_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [2:0] events;
    logic [7:0] rd_val;
    wave_mode_type wave_mode;
    logic is_plain;
    logic is_fast;
    logic is_phase;
    logic top_from_a;
    logic tick;
    logic [7:0] top;
    logic at_top;
    logic wrap;
    logic match_a;
    logic match_b;
    logic ovf_evt;
    logic load_cmp;
    logic addr_take;
    logic wr_en;
    logic wave_a;
    logic wave_b;
    logic conn_a;
    logic conn_b;

    // Mode decode from both control registers
    assign wave_mode = {ctl_b_r[`BIT_HIGH], ctl_a_r[1:0]};
    assign is_plain = (wave_mode == `MODE_NORMAL) || (wave_mode == `MODE_CLR_CMP);
    assign is_fast = (wave_mode == `MODE_FAST_FF) || (wave_mode == `MODE_FAST_A);
    assign is_phase = (wave_mode == `MODE_PC_FF) || (wave_mode == `MODE_PC_A);
    assign top_from_a = (wave_mode == `MODE_CLR_CMP) || (wave_mode == `MODE_PC_A)
        || (wave_mode == `MODE_FAST_A);

    // Reserved modes halt the counter and freeze the outputs
    assign tick = ctl_b_r[`BIT_RUN] && (is_plain || is_fast || is_phase);

    // Ceiling: fixed maximum or compare A
    assign top = top_from_a ? cmp_a_act_r : `COUNT_MAX;
    assign at_top = (count_r == top);
    assign wrap = tick && is_fast && at_top;

    // Compare matches, suppressed on the step after a counter write
    assign match_a = tick && !block_r && (count_r == cmp_a_act_r);
    assign match_b = tick && !block_r && (count_r == cmp_b_act_r);

    // Overflow timing per mode; maximum is fixed except in fast mode A, where it is compare A; floor is zero
    always_comb begin
        ovf_evt = 1'b0;
        if (tick) begin
            if (is_phase) begin
                ovf_evt = (count_r == `COUNT_FLOOR) && !dir_up_r;
            end else if (wave_mode == `MODE_FAST_A) begin
                ovf_evt = at_top;
            end else begin
                ovf_evt = (count_r == `COUNT_MAX);
            end
        end
    end

    // Next count and direction
    always_comb begin
        count_nxt = count_r;
        dir_up_nxt = dir_up_r;
        if (tick) begin
            if (is_phase) begin
                if (dir_up_r) begin
                    if (at_top) begin
                        dir_up_nxt = 1'b0;
                        count_nxt = count_r - 8'h01;
                    end else begin
                        count_nxt = count_r + 8'h01;
                    end
                end else if (count_r == `COUNT_FLOOR) begin
                    dir_up_nxt = 1'b1;
                    count_nxt = count_r + 8'h01;
                end else begin
                    count_nxt = count_r - 8'h01;
                end
            end else if (wave_mode == `MODE_NORMAL) begin
                count_nxt = count_r + 8'h01;
            end else if (at_top) begin
                count_nxt = `COUNT_FLOOR;
            end else begin
                count_nxt = count_r + 8'h01;
            end
        end
    end

    // Compare buffer load point
    assign load_cmp = is_plain || (wrap)
        || (tick && is_phase && dir_up_r && at_top);

    // Bus address phase and write strobe
    assign addr_take = hsel && hready && htrans[1];
    assign wr_en = (bus_r == bus_write);

    // Bus handshake state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_r <= bus_idle;
            addr_r <= 32'h0000_0000;
        end else begin
            case (bus_r)
                bus_read_wait: bus_r <= bus_read_done;
                default: begin
                    if (addr_take) begin
                        addr_r <= haddr;
                        bus_r <= hwrite ? bus_write : bus_read_wait;
                    end else begin
                        bus_r <= bus_idle;
                    end
                end
            endcase
        end
    end

    // Reads take one wait state; writes none
    assign hreadyout = (bus_r != bus_read_wait);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Read value by address; unmapped reads return zero
    always_comb begin
        rd_val = `RST_BYTE;
        if (addr_r == `OFF_CTL_A) begin
            rd_val = ctl_a_r & `CTL_A_RMASK;
        end else if (addr_r == `OFF_CTL_B) begin
            rd_val = ctl_b_r;
        end else if (addr_r == `OFF_COUNT) begin
            rd_val = count_r;
        end else if (addr_r == `OFF_CMP_A) begin
            rd_val = cmp_a_wr_r;
        end else if (addr_r == `OFF_CMP_B) begin
            rd_val = cmp_b_wr_r;
        end else if (addr_r == `OFF_STATUS) begin
            rd_val = {5'h00, status_r};
        end else if (addr_r == `OFF_MASK) begin
            rd_val = {5'h00, mask_r};
        end else if (addr_r == `OFF_PINS) begin
            rd_val = {4'h0, conn_b, conn_a, wave_b, wave_a};
        end
    end

    // Read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (bus_r == bus_read_wait) begin
            hrdata_r <= {24'h00_0000, rd_val};
        end
    end

    // Control register A; bits 3 and 2 are never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_a_r <= `RST_BYTE;
        end else if (wr_en && addr_r == `OFF_CTL_A) begin
            ctl_a_r <= hwdata[7:0] & `CTL_A_RMASK;
        end
    end

    // Control register B: high mode bit and run enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_b_r <= `RST_BYTE;
        end else if (wr_en && addr_r == `OFF_CTL_B) begin
            ctl_b_r <= {6'h00, hwdata[`BIT_RUN], hwdata[`BIT_HIGH]};
        end
    end

    // Counter, direction and match blocking after a counter write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= `COUNT_FLOOR;
            dir_up_r <= 1'b1;
            block_r <= 1'b0;
        end else if (wr_en && addr_r == `OFF_COUNT) begin
            count_r <= hwdata[7:0];
            block_r <= 1'b1;
        end else begin
            count_r <= count_nxt;
            dir_up_r <= dir_up_nxt;
            if (tick) begin
                block_r <= 1'b0;
            end
        end
    end

    // Software-written compare values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_a_wr_r <= `RST_BYTE;
            cmp_b_wr_r <= `RST_BYTE;
        end else if (wr_en) begin
            if (addr_r == `OFF_CMP_A) begin
                cmp_a_wr_r <= hwdata[7:0];
            end else if (addr_r == `OFF_CMP_B) begin
                cmp_b_wr_r <= hwdata[7:0];
            end
        end
    end

    // Active compare values, loaded at the mode's update point
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_a_act_r <= `RST_BYTE;
            cmp_b_act_r <= `RST_BYTE;
        end else if (load_cmp) begin
            cmp_a_act_r <= cmp_a_wr_r;
            cmp_b_act_r <= cmp_b_wr_r;
        end
    end

    // Sticky events; a new event wins over a write-one clear
    assign events = {match_b, match_a, ovf_evt};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= `RST_FLAGS;
        end else if (wr_en && addr_r == `OFF_STATUS) begin
            status_r <= (status_r & ~hwdata[2:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    // Interrupt mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_r <= `RST_FLAGS;
        end else if (wr_en && addr_r == `OFF_MASK) begin
            mask_r <= hwdata[2:0];
        end
    end

    // Level interrupt while any unmasked flag stands
    assign irq = |(status_r & mask_r);

    // Channel A: PWM toggle allowed with the high mode bit
    wave_channel #(
        .ALLOW_PWM_TOGGLE(1'b1)
    ) u_chan_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .is_plain(is_plain),
        .is_fast(is_fast),
        .is_phase(is_phase),
        .wave_mode_high(ctl_b_r[`BIT_HIGH]),
        .out_mode(ctl_a_r[7:6]),
        .match(match_a),
        .cmp_is_top(cmp_a_act_r == top),
        .wrap(wrap),
        .counting_up(dir_up_r),
        .wave_out(wave_a),
        .connected(conn_a)
    );

    // Channel B: code 01 reserved in PWM modes
    wave_channel #(
        .ALLOW_PWM_TOGGLE(1'b0)
    ) u_chan_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .is_plain(is_plain),
        .is_fast(is_fast),
        .is_phase(is_phase),
        .wave_mode_high(ctl_b_r[`BIT_HIGH]),
        .out_mode(ctl_a_r[5:4]),
        .match(match_b),
        .cmp_is_top(cmp_b_act_r == top),
        .wrap(wrap),
        .counting_up(dir_up_r),
        .wave_out(wave_b),
        .connected(conn_b)
    );

    // Pin takeover; the driver stays under the port direction bit
    assign pin_a_o = conn_a ? wave_a : port_out_a;
    assign pin_b_o = conn_b ? wave_b : port_out_b;
    assign pin_a_oe = port_dir_a;
    assign pin_b_oe = port_dir_b;
endmodule
`default_nettype wire

// ---- hw/timer8_params.svh ----
// Constants for the 8-bit timer waveform control block.
// Assumes a 32-bit AHB-Lite register bus; included by the design files.
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH

// Register byte offsets
`define OFF_CTL_A 32'h0000_0024
`define OFF_CTL_B 32'h0000_0028
`define OFF_COUNT 32'h0000_002c
`define OFF_CMP_A 32'h0000_0030
`define OFF_CMP_B 32'h0000_0034
`define OFF_STATUS 32'h0000_0038
`define OFF_MASK 32'h0000_003c
`define OFF_PINS 32'h0000_0040

// Field layout and reset values
`define CTL_A_RMASK 8'hf3
`define RST_BYTE 8'h00
`define BIT_HIGH 0
`define BIT_RUN 1
`define ST_OVF 0
`define ST_MA 1
`define ST_MB 2
`define RST_FLAGS 3'h0

// Mode codes and counts
`define MODE_NORMAL 3'h0
`define MODE_PC_FF 3'h1
`define MODE_CLR_CMP 3'h2
`define MODE_FAST_FF 3'h3
`define MODE_PC_A 3'h5
`define MODE_FAST_A 3'h7
`define COUNT_MAX 8'hff
`define COUNT_FLOOR 8'h00
`define OM_OFF 2'h0
`define OM_TOGGLE 2'h1

`endif

// ---- hw/timer8_pkg.sv ----
// Types shared by the timer waveform control block.
// Assumes nothing of its surroundings.
package timer8_pkg;
    typedef logic [2:0] wave_mode_type;
    typedef logic [1:0] out_mode_type;
    typedef enum logic [1:0] {
        bus_idle,
        bus_write,
        bus_read_wait,
        bus_read_done
    } bus_state_type;
endpackage

// ---- hw/wave_channel.sv ----
// One waveform output channel: reacts to matches and counter turning points.
// Assumes the counter core gives one-cycle tick, match and wrap strobes.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"

module wave_channel #(
    parameter bit ALLOW_PWM_TOGGLE = 1'b1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Mode and timing strobes
    input wire logic tick,
    input wire logic is_plain,
    input wire logic is_fast,
    input wire logic is_phase,
    input wire logic wave_mode_high,
    input wire timer8_pkg::out_mode_type out_mode,
    input wire logic match,
    input wire logic cmp_is_top,
    input wire logic wrap,
    input wire logic counting_up,
    // Waveform state
    output logic wave_out,
    output logic connected
);
    import timer8_pkg::*;

    logic pwm_toggle_ok;

    // Toggle in PWM modes exists only on channel A with the high bit set
    assign pwm_toggle_ok = ALLOW_PWM_TOGGLE && wave_mode_high;
    // Channel A code 01 without the high bit leaves the pin to the port in PWM modes
    assign connected = (out_mode != `OM_OFF)
        && !(ALLOW_PWM_TOGGLE && (is_fast || is_phase) && (out_mode == `OM_TOGGLE)
        && !wave_mode_high);

    // Output register update per timer step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wave_out <= 1'b0;
        end else if (tick) begin
            if (is_plain) begin
                if (match) begin
                    // Toggle, clear or set on match
                    case (out_mode)
                        2'h1: wave_out <= ~wave_out;
                        2'h2: wave_out <= 1'b0;
                        2'h3: wave_out <= 1'b1;
                        default: wave_out <= wave_out;
                    endcase
                end
            end else if (is_fast) begin
                if (out_mode[1]) begin
                    if (wrap) begin
                        // Floor action; also covers compare at ceiling
                        wave_out <= ~out_mode[0];
                    end else if (match && !cmp_is_top) begin
                        wave_out <= out_mode[0];
                    end
                end else if (out_mode == `OM_TOGGLE && pwm_toggle_ok && match) begin
                    wave_out <= ~wave_out;
                end
            end else if (is_phase) begin
                if (out_mode[1] && match) begin
                    if (cmp_is_top) begin
                        // Ceiling action in place of the match
                        wave_out <= ~out_mode[0];
                    end else if (counting_up) begin
                        wave_out <= out_mode[0];
                    end else begin
                        wave_out <= ~out_mode[0];
                    end
                end else if (out_mode == `OM_TOGGLE && pwm_toggle_ok && match) begin
                    wave_out <= ~wave_out;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/timer8_wave_ctrl_properties.sv ----
// Checker for the timer wave control block: bus timing, pin takeover, control A.
// Assumes hready is tied to hreadyout and a single non-pipelining master.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"
module timer8_wave_ctrl_properties (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Port and pins
    input wire logic port_out_a,
    input wire logic port_dir_a,
    input wire logic port_out_b,
    input wire logic port_dir_b,
    input wire logic pin_a_o,
    input wire logic pin_a_oe,
    input wire logic pin_b_o,
    input wire logic pin_b_oe
);
    logic take;
    logic rd_ctl;
    logic wr_ph_r;
    logic rd_ph_r;
    logic [31:0] addr_r;
    logic [7:0] ctl_r;
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Accepted address phase and control A read completion
    assign take = hsel && hready && htrans[1];
    assign rd_ctl = rd_ph_r && hreadyout && (addr_r == `OFF_CTL_A);
    // Data phase tracking and a shadow of control A
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_r <= 1'b0;
            rd_ph_r <= 1'b0;
            addr_r <= 32'h0;
            ctl_r <= 8'h00;
        end else if (hready) begin
            wr_ph_r <= take && hwrite;
            rd_ph_r <= take && !hwrite;
            if (take) begin
                addr_r <= haddr;
            end
            if (wr_ph_r && addr_r == `OFF_CTL_A) begin
                ctl_r <= hwdata[7:0] & `CTL_A_RMASK;
            end
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not OKAY");
    a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_dir_drives_pins: assert property (
        pin_a_oe == port_dir_a && pin_b_oe == port_dir_b)
        else $error("pin enable differs from direction");
    a_port_owns_a: assert property (
        ctl_r[7:6] == 2'b00 && $past(ctl_r[7:6]) == 2'b00 |-> pin_a_o == port_out_a)
        else $error("pin A not following port");
    a_port_owns_b: assert property (
        ctl_r[5:4] == 2'b00 && $past(ctl_r[5:4]) == 2'b00 |-> pin_b_o == port_out_b)
        else $error("pin B not following port");
    a_ctl_spare_zero: assert property (rd_ctl |-> hrdata[3:2] == 2'b00)
        else $error("spare control bits read nonzero");
    a_ctl_readback: assert property (rd_ctl |-> hrdata == {24'h0, ctl_r})
        else $error("control A readback wrong");
endmodule
`default_nettype wire

// ---- dv/pin_model.sv ----
// One port pin driven by a waveform output.
// Assumes no pull resistor: an undriven pin shows a changing level.
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    // Clock
    input wire logic hclk,
    // Driver
    input wire logic pin_o,
    input wire logic pin_oe,
    // Pin level
    output logic level
);
    logic last_r = 1'b0;
    // Remember the level so a floating pin flips every cycle
    always_ff @(posedge hclk) begin
        last_r <= level;
    end
    // Driven only while the direction is output
    assign level = pin_oe ? pin_o : ~last_r;
endmodule
`default_nettype wire

// ---- dv/timer8_wave_ctrl_tb_top.sv ----
// Self-checking bench for the timer wave control block.
// Assumes the design, the pin model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"
module timer8_wave_ctrl_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, lvl_a, lvl_b;
    logic pin_a_o, pin_a_oe, pin_b_o, pin_b_oe;
    logic port_out_a = 1'b0;
    logic port_out_b = 1'b0;
    logic port_dir_a = 1'b1; // Pin A set to output
    logic port_dir_b = 1'b1;
    logic rd_ph = 1'b0;
    logic [31:0] seed = 32'hfd05ea27;
    logic [31:0] exp_q[$];
    int errors = 0;
    int checked = 0;
    always #2 hclk = ~hclk;
    timer8_wave_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_out_a(port_out_a),
        .port_dir_a(port_dir_a), .port_out_b(port_out_b), .port_dir_b(port_dir_b),
        .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe),
        .irq(irq));
    pin_model pin_a (.hclk(hclk), .pin_o(pin_a_o), .pin_oe(pin_a_oe), .level(lvl_a));
    pin_model pin_b (.hclk(hclk), .pin_o(pin_b_o), .pin_oe(pin_b_oe), .level(lvl_b));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One single transfer: address phase, then data phase
    task automatic bus_op(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus_op(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus_op(1'b0, a, 32'h0);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge hclk);
        check_val("irq", {31'h0, e}, {31'h0, irq});
    endtask
    // Set mode and compares, run about 43 steps, stop, then read the wave state
    task automatic run_case(input logic [7:0] ca, input logic hb, input logic [7:0] cnt,
        input logic [7:0] cpa, input logic [7:0] cpb, input logic [3:0] pins);
        wr(`OFF_CTL_B, {30'h0, 1'b0, hb});
        wr(`OFF_CTL_A, {24'h0, ca});
        wr(`OFF_CMP_A, {24'h0, cpa});
        wr(`OFF_CMP_B, {24'h0, cpb});
        wr(`OFF_COUNT, {24'h0, cnt});
        wr(`OFF_CTL_B, {30'h0, 1'b1, hb});
        repeat (40) @(posedge hclk);
        wr(`OFF_CTL_B, {30'h0, 1'b0, hb});
        rd(`OFF_PINS, {28'h0, pins});
        check_val("pin_a", {31'h0, pins[0]}, {31'h0, lvl_a});
        check_val("pin_b", {31'h0, pins[1]}, {31'h0, lvl_b});
    endtask
    // Random port levels reach the pins while a channel is disconnected
    always @(posedge hclk) begin
        seed <= lfsr(seed);
        port_out_a <= seed[3];
        port_out_b <= seed[9];
    end
    // Compare each read result with the oldest note
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            rd_ph = 1'b0;
            check_val("hrdata", exp_q.pop_front(), hrdata);
        end
        if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1) begin
            rd_ph = 1'b1;
        end
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(`OFF_CTL_A + 4 * i, 32'h0);
        end
        rd(32'h0000_0080, 32'h0);
        repeat (4) begin
            r = seed;
            wr(`OFF_CTL_A, r);
            rd(`OFF_CTL_A, {24'h0, r[7:0] & `CTL_A_RMASK});
        end
        run_case(8'he0, 1'b0, 8'h00, 8'h05, 8'h07, 4'hd);
        run_case(8'h50, 1'b0, 8'h00, 8'h05, 8'h07, 4'he);
        run_case(8'hb3, 1'b0, 8'hf0, 8'h40, 8'h40, 4'hd);
        run_case(8'he3, 1'b0, 8'hf0, 8'h40, 8'h40, 4'he);
        run_case(8'hb1, 1'b0, 8'hf0, 8'hf8, 8'hf8, 4'hd);
        run_case(8'hb2, 1'b0, 8'h00, 8'h08, 8'h06, 4'he);
        run_case(8'h63, 1'b1, 8'h00, 8'h0b, 8'h02, 4'hd);
        wr(`OFF_STATUS, 32'h7);
        run_case(8'he0, 1'b0, 8'hf0, 8'h05, 8'h80, 4'hd);
        rd(`OFF_STATUS, 32'h3);
        chk_irq(1'b0);
        wr(`OFF_MASK, 32'h4);
        chk_irq(1'b0);
        wr(`OFF_MASK, 32'h2);
        chk_irq(1'b1);
        wr(`OFF_STATUS, 32'h2);
        chk_irq(1'b0);
        rd(`OFF_STATUS, 32'h1);
        rd(`OFF_MASK, 32'h2);
        // Release pin B: its driver must follow the direction bit
        port_dir_b <= 1'b0;
        @(posedge hclk);
        check_val("pin_b_oe", 32'h0, {31'h0, pin_b_oe});
        // Let the last read compare run before the verdict
        repeat (2) @(posedge hclk);
        check_val("reads_left", 32'h0, exp_q.size());
        wrap_up();
    end
    // Watchdog against a hung handshake
    initial begin
        #80000;
        errors++;
        wrap_up();
    end
endmodule
bind timer8_wave_ctrl timer8_wave_ctrl_properties chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port_out_a(port_out_a), .port_dir_a(port_dir_a), .port_out_b(port_out_b),
    .port_dir_b(port_dir_b), .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o),
    .pin_b_oe(pin_b_oe));
`default_nettype wire
